// >>> design/sir_core_if.sv
`default_nettype none
// ****************************************
// links between the top and its helpers
// ****************************************
interface sir_core_if;
    logic baud_tick;        // one-cycle pulse per 16x baud period
    logic tx_on;            // encoder allowed to run
    logic uart_txd;         // uart transmit level
    logic tx_symbol;        // encoded pulse, high during 3/16 pulse
    logic rx_on;            // decoder allowed to run
    logic rx_level;         // receive level, low during a pulse
    logic [3:0] div_factor; // pulse_divider_factor
    logic pulse_ok;         // one-cycle: a legal pulse was seen
    modport top (output baud_tick, tx_on, uart_txd, rx_on, rx_level, div_factor,
                 input tx_symbol, pulse_ok);
    modport enc (input baud_tick, tx_on, uart_txd, output tx_symbol);
    modport qual (input baud_tick, rx_on, rx_level, div_factor, output pulse_ok);
endinterface
`default_nettype wire

// >>> design/sir_encoder.sv
`default_nettype none
// ****************************************
// 3/16 pulse encoder
// ****************************************
module sir_encoder (
    input wire logic i_core_clk,  // system clock
    input wire logic i_resetn,    // async reset, active low
    sir_core_if.enc link          // tick, txd in, symbol out
);
    logic [3:0] phase;    // tick position inside the bit
    logic bit_val;        // bit being encoded
    logic last_txd;       // txd at the previous tick

    // bit framing: a txd change restarts the bit so symbols track the uart
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            phase <= 4'h0;
            bit_val <= 1'b1;
            last_txd <= 1'b1;
        end
        else if (!link.tx_on)
        begin
            phase <= 4'h0;
            bit_val <= 1'b1;
            last_txd <= 1'b1;
        end
        else if (link.baud_tick)
        begin
            last_txd <= link.uart_txd;
            if (link.uart_txd != last_txd || phase == sir_pkg::SYM_LAST) // RULE_01
            begin
                phase <= 4'h0;
                bit_val <= link.uart_txd;
            end
            else
                phase <= phase + 4'h1;
        end
    end

    // pulse only for a zero, ticks 7..9; a one stays low all 16 ticks
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            link.tx_symbol <= 1'b0;
        else
            link.tx_symbol <= link.tx_on && !bit_val && phase >= sir_pkg::SYM_HIGH_FIRST
                              && phase <= sir_pkg::SYM_HIGH_LAST; // RULE_02 RULE_03
    end
endmodule
`default_nettype wire

// >>> design/sir_endec_top.sv
// Contract
// RULE_01 - each uart bit is sixteen baud ticks
// RULE_02 - a one bit keeps the output low
// RULE_03 - a zero: low 7, high 3, low 6
// RULE_04 - no transmit while receive decode enabled
// RULE_05 - a short low pulse decodes as zero
// RULE_06 - sixteen quiet ticks decode as one
// RULE_07 - pass pulses within minimum and maximum width
// RULE_08 - divider is factor plus two ones
// RULE_09 - factor zero selects plain edge detection
// RULE_10 - software picks factor from clock rate
// RULE_11 - software follows the clock range table
// RULE_12 - later decoded bits are exactly sixteen ticks
// RULE_13 - loopback feeds inverted output to decoder
// RULE_14 - receive enable routes decoded data to uart
// RULE_15 - bit zero switches the whole endec
// RULE_16 - control resets zero, unused bits read zero
// RULE_17 - software sets pins to alternate function
// RULE_18 - software masks uart modem status interrupt
// RULE_19 - timing follows the uart baud clock
// RULE_20 - idle receive line held high
`default_nettype none
module sir_endec_top (
    input wire logic i_core_clk,        // system clock, 40 mhz
    input wire logic i_resetn,          // async reset, active low
    input wire logic [11:0] i_paddr,    // apb byte address
    input wire logic i_psel,            // apb select
    input wire logic i_penable,         // apb access phase
    input wire logic i_pwrite,          // apb write when high
    input wire logic [31:0] i_pwdata,   // apb write data
    output logic [31:0] o_prdata,       // apb read data
    output logic o_pready,              // apb ready
    output logic o_pslverr,             // apb error, unmapped address
    input wire logic i_baud_clk16,      // uart 16x baud clock
    input wire logic i_uart_txd,        // uart transmit serial line
    output logic o_uart_rxd,            // uart receive serial line
    input wire logic i_infrared_in,     // infrared_in pin, low = pulse
    output logic o_infrared_out         // infrared_out pin, high = pulse
);
    // ****************************************
    // declarations
    // ****************************************
    sir_core_if link ();        // shared with encoder and qualifier
    logic [7:0] ctrl;           // infrared_endec_control
    logic [2:0] baud_sync;      // baud clock sync and edge stage
    logic [1:0] ir_sync;        // infrared_in synchroniser
    logic [4:0] win_cnt;        // ticks left in a decoded zero
    logic apb_setup;            // setup phase of any transfer
    logic apb_access;           // access phase of any transfer
    logic addr_hit;             // address maps to the control
    logic endec_enable;         // control bit 0
    logic rx_decode_enable;     // control bit 1
    logic loopback;             // control bit 2

    // ****************************************
    // control fields
    // ****************************************
    // field decode straight off the control register
    always_comb
    begin
        endec_enable = ctrl[sir_pkg::EN_BIT];
        rx_decode_enable = ctrl[sir_pkg::RXEN_BIT];
        loopback = ctrl[sir_pkg::LOOP_BIT];
    end

    // ****************************************
    // apb slave
    // ****************************************
    // zero wait states: every access completes in its first access cycle
    always_comb
    begin
        apb_setup = i_psel && !i_penable;
        apb_access = i_psel && i_penable;
        addr_hit = i_paddr == sir_pkg::CTRL_ADDR;
        o_pready = 1'b1;
        o_pslverr = apb_access && !addr_hit; // unmapped answers with error
    end

    // control register; unused bit 3 can never be set
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            ctrl <= sir_pkg::CTRL_RESET; // RULE_16
        else if (apb_access && i_pwrite && addr_hit)
            ctrl <= i_pwdata[7:0] & sir_pkg::CTRL_WMASK; // RULE_16
    end

    // read data captured in setup so it comes from a flip-flop
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            o_prdata <= 32'h0000_0000;
        else if (apb_setup && !i_pwrite && addr_hit)
            o_prdata <= {24'h00_0000, ctrl}; // upper bits read zero
        else if (apb_setup)
            o_prdata <= 32'h0000_0000; // unmapped reads zero
    end

    // ****************************************
    // input synchronisers
    // ****************************************
    // baud clock is foreign; third stage only feeds the edge detect
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            baud_sync <= 3'h0;
        else
            baud_sync <= {baud_sync[1:0], i_baud_clk16};
    end

    // infrared pin idles high, so reset to the idle level
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            ir_sync <= 2'h3;
        else
            ir_sync <= {ir_sync[0], i_infrared_in};
    end

    // ****************************************
    // helper wiring
    // ****************************************
    // baud clock must be slower than half the core clock, else ticks are lost
    always_comb
    begin
        link.baud_tick = baud_sync[1] && !baud_sync[2]; // RULE_19
        link.uart_txd = i_uart_txd;
        // loopback keeps the encoder running even with decode enabled
        link.tx_on = endec_enable && (!rx_decode_enable || loopback); // RULE_04 RULE_15
        link.rx_on = endec_enable && rx_decode_enable; // RULE_14 RULE_15
        link.rx_level = loopback ? !link.tx_symbol : ir_sync[1]; // RULE_13
        link.div_factor = ctrl[sir_pkg::DIV_LSB +: sir_pkg::DIV_W];
    end

    // ****************************************
    // encoder and qualifier
    // ****************************************
    sir_encoder u_encoder (
        .i_core_clk (i_core_clk),
        .i_resetn (i_resetn),
        .link (link.enc)
    );

    sir_pulse_qual u_qual (
        .i_core_clk (i_core_clk),
        .i_resetn (i_resetn),
        .link (link.qual)
    );

    // ****************************************
    // pin output
    // ****************************************
    // half duplex: pin stays low whenever decode is enabled
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            o_infrared_out <= 1'b0;
        else
            o_infrared_out <= endec_enable && !rx_decode_enable && link.tx_symbol; // RULE_04
    end

    // ****************************************
    // decoded receive stream
    // ****************************************
    // every legal pulse opens a sixteen-tick zero; a retrigger keeps later
    // bits exactly sixteen ticks, only the first one carries sampling jitter
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            win_cnt <= 5'h00;
        else if (!link.rx_on)
            win_cnt <= 5'h00;
        else if (link.pulse_ok)
            win_cnt <= sir_pkg::SYM_TICKS; // RULE_05 RULE_12
        else if (link.baud_tick && win_cnt != 5'h00)
            win_cnt <= win_cnt - 5'h01; // RULE_06
    end

    // uart line idles high while off or not decoding
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            o_uart_rxd <= 1'b1;
        else
            o_uart_rxd <= !(link.rx_on && win_cnt != 5'h00); // RULE_14 RULE_20
    end

    // ****************************************
    // checking helpers
    // ****************************************
    logic [2:0] hi_ticks;   // ticks seen while the symbol is high
    logic [4:0] txd_hi;     // ticks of steady high txd, saturating
    logic [6:0] low_clks;   // cycles the receive level has been low
    logic [4:0] quiet;      // ticks since the last legal pulse

    // counters only the assertions read
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            hi_ticks <= 3'h0;
            txd_hi <= 5'h00;
            low_clks <= 7'h00;
            quiet <= 5'h00;
        end
        else
        begin
            if (!link.tx_symbol)
                hi_ticks <= 3'h0;
            else if (link.baud_tick && hi_ticks != 3'h7)
                hi_ticks <= hi_ticks + 3'h1;
            if (!i_uart_txd || !link.tx_on)
                txd_hi <= 5'h00;
            else if (link.baud_tick && txd_hi != 5'h1f)
                txd_hi <= txd_hi + 5'h01;
            if (link.rx_level)
                low_clks <= 7'h00;
            else if (low_clks != 7'h7f)
                low_clks <= low_clks + 7'h01;
            if (link.pulse_ok || !link.rx_on)
                quiet <= 5'h00;
            else if (link.baud_tick && quiet != 5'h1f)
                quiet <= quiet + 5'h01;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    a_ctrl_write_mask: assert property ( // RULE_16
        @(posedge i_core_clk) disable iff (!i_resetn)
        apb_access && i_pwrite && addr_hit |=> ctrl == ($past(i_pwdata[7:0]) & 8'hf7))
        else $error("control write mask wrong");

    a_rx_idle_high: assert property ( // RULE_20
        @(posedge i_core_clk) disable iff (!i_resetn)
        !link.rx_on |=> o_uart_rxd)
        else $error("uart rx not idle while decode off");

    a_pulse_three_ticks: assert property ( // RULE_03
        @(posedge i_core_clk) disable iff (!i_resetn)
        $fell(link.tx_symbol) && $past(link.tx_on) |-> hi_ticks == 3'h3)
        else $error("zero pulse not three ticks wide");

    a_one_stays_low: assert property ( // RULE_02
        @(posedge i_core_clk) disable iff (!i_resetn)
        txd_hi > 5'h11 |-> !link.tx_symbol)
        else $error("pulse sent for a one bit");

    a_half_duplex: assert property ( // RULE_04
        @(posedge i_core_clk) disable iff (!i_resetn)
        rx_decode_enable |=> !o_infrared_out)
        else $error("transmit while decode enabled");

    a_edge_mode: assert property ( // RULE_09
        @(posedge i_core_clk) disable iff (!i_resetn)
        link.rx_on && $past(link.rx_on) && link.div_factor == 4'h0
        && $past(link.div_factor) == 4'h0 && $fell(link.rx_level) |=> link.pulse_ok)
        else $error("edge mode missed a pulse");

    a_short_reject: assert property ( // RULE_07
        @(posedge i_core_clk) disable iff (!i_resetn)
        link.rx_on && link.div_factor != 4'h0 && $stable(link.div_factor)
        && $rose(link.rx_level) && low_clks <= {1'b0, link.div_factor, 2'h3} + 7'h01
        |=> !link.pulse_ok)
        else $error("short pulse accepted");

    a_zero_decoded: assert property ( // RULE_05
        @(posedge i_core_clk) disable iff (!i_resetn)
        link.pulse_ok && link.rx_on ##1 link.rx_on |=> !o_uart_rxd)
        else $error("legal pulse not decoded as zero");

    a_quiet_one: assert property ( // RULE_06
        @(posedge i_core_clk) disable iff (!i_resetn)
        quiet > 5'h11 |-> o_uart_rxd)
        else $error("quiet bit not decoded as one");

    a_window_reload: assert property ( // RULE_12
        @(posedge i_core_clk) disable iff (!i_resetn)
        link.pulse_ok && link.rx_on |=> win_cnt == 5'h10)
        else $error("zero window not sixteen ticks");

    a_loopback_path: assert property ( // RULE_13
        @(posedge i_core_clk) disable iff (!i_resetn)
        $rose(link.tx_symbol) && loopback && $past(loopback) && link.rx_on
        && $past(link.rx_on) && link.div_factor == 4'h0 && $past(link.div_factor) == 4'h0
        |=> link.pulse_ok)
        else $error("loopback pulse not seen");
endmodule
`default_nettype wire

// >>> design/sir_pkg.sv
`default_nettype none
// ****************************************
// shared constants for the infrared endec
// ****************************************
package sir_pkg;
    // register map: printed offset is an index, byte address is four times it
    localparam logic [11:0] CTRL_INDEX = 12'h00bf;
    localparam logic [11:0] CTRL_ADDR = 12'(CTRL_INDEX << 2);
    localparam logic [7:0] CTRL_RESET = 8'h00;  // control after reset
    localparam logic [7:0] CTRL_WMASK = 8'hf7;  // bit 3 is unused
    // control field positions
    localparam int unsigned EN_BIT = 0;         // endec_enable
    localparam int unsigned RXEN_BIT = 1;       // rx_decode_enable
    localparam int unsigned LOOP_BIT = 2;       // internal loopback
    localparam int unsigned DIV_LSB = 4;        // pulse_divider_factor low bit
    localparam int unsigned DIV_W = 4;          // pulse_divider_factor width
    // divider low bits are fixed
    localparam logic [1:0] DIV_LOW_BITS = 2'h3;
    // symbol timing in baud ticks
    localparam logic [4:0] SYM_TICKS = 5'h10;   // ticks per uart bit
    localparam logic [3:0] SYM_HIGH_FIRST = 4'h7; // first tick of the pulse
    localparam logic [3:0] SYM_HIGH_LAST = 4'h9;  // last tick of the pulse
    localparam logic [3:0] SYM_LAST = 4'hf;     // last tick of a bit
    localparam logic [2:0] MAX_PULSE_TICKS = 3'h4; // longest legal low pulse
    // pulse qualifier states
    typedef enum logic [2:0]
    {
        Q_IDLE = 3'b001,
        Q_MEASURE = 3'b010,
        Q_WAIT = 3'b100
    } sir_qual_state_type;
endpackage
`default_nettype wire

// >>> design/sir_pulse_qual.sv
`default_nettype none
// ****************************************
// receive pulse width qualifier
// ****************************************
module sir_pulse_qual (
    input wire logic i_core_clk,  // system clock
    input wire logic i_resetn,    // async reset, active low
    sir_core_if.qual link         // level in, pulse_ok out
);
    sir_pkg::sir_qual_state_type state; // qualifier state
    logic [5:0] div_cnt;  // six-bit divider, counts down
    logic min_met;        // one divider period elapsed while low
    logic [2:0] tick_cnt; // baud ticks spent low

    // measure each low pulse when factor is nonzero, too short or too long is dropped; factor zero passes every pulse at its falling edge
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            state <= sir_pkg::Q_IDLE;
            div_cnt <= 6'h00;
            min_met <= 1'b0;
            tick_cnt <= 3'h0;
            link.pulse_ok <= 1'b0;
        end
        else
        begin
            link.pulse_ok <= 1'b0;
            case (state)
                sir_pkg::Q_IDLE:
                    if (link.rx_on && !link.rx_level)
                    begin
                        if (link.div_factor == 4'h0)
                        begin
                            link.pulse_ok <= 1'b1; // RULE_09
                            state <= sir_pkg::Q_WAIT;
                        end
                        else
                        begin
                            div_cnt <= {link.div_factor, sir_pkg::DIV_LOW_BITS}; // RULE_08
                            min_met <= 1'b0;
                            tick_cnt <= 3'h0;
                            state <= sir_pkg::Q_MEASURE;
                        end
                    end
                sir_pkg::Q_MEASURE:
                    if (!link.rx_on)
                        state <= sir_pkg::Q_IDLE;
                    else if (link.rx_level)
                    begin
                        link.pulse_ok <= min_met; // RULE_07
                        state <= sir_pkg::Q_IDLE;
                    end
                    else
                    begin
                        if (div_cnt == 6'h00)
                            min_met <= 1'b1;
                        else
                            div_cnt <= div_cnt - 6'h01;
                        if (link.baud_tick && tick_cnt == sir_pkg::MAX_PULSE_TICKS)
                            state <= sir_pkg::Q_WAIT; // RULE_07
                        else if (link.baud_tick)
                            tick_cnt <= tick_cnt + 3'h1;
                    end
                sir_pkg::Q_WAIT:
                    if (!link.rx_on || link.rx_level)
                        state <= sir_pkg::Q_IDLE;
                default:
                    state <= sir_pkg::Q_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> verif/sir_xcvr_model.sv
`default_nettype none
// ****************************************
// infrared transceiver stand-in
// ****************************************
module sir_xcvr_model (
    input wire logic i_clk,        // core clock
    input wire logic i_led,        // led drive, high = light
    input wire logic i_req,        // one-cycle request to send a pulse
    input wire logic [7:0] i_len,  // pulse length in core cycles
    output logic o_rxd,            // receiver output, low = light seen
    output logic [7:0] o_width     // width of the last led pulse
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] left = 8'h00;  // pulse cycles still to send
    logic [7:0] run = 8'h00;   // length of the led pulse in progress
    // pulse length is commanded, so the bench can send short and long ones
    always @(posedge i_clk)
    begin
        if (i_req)
            left <= i_len;
        else if (left != 8'h00)
            left <= left - 8'h01;
    end
    // the receiver idles high and only drops while a requested pulse is being sent
    assign o_rxd = (left == 8'h00);
    // measure each led pulse, last one kept for the bench
    initial o_width = 8'h00;
    always @(posedge i_clk)
    begin
        if (i_led)
            run <= run + 8'h01;
        else if (run != 8'h00)
        begin
            o_width <= run;
            run <= 8'h00;
        end
    end
endmodule
`default_nettype wire

// >>> verif/tb_infrared_sir_endec.sv
`default_nettype none
module tb_infrared_sir_endec;
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************
    // stimulus and observed signals
    // ****************************************
    logic i_core_clk = 1'b0;  // 40 mhz core clock
    logic i_resetn = 1'b0;    // reset, active low
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] bcnt = 2'h0;  // baud divider, tick every 4 core cycles
    logic baud = 1'b0;        // 16x baud clock, 2 high 2 low
    logic txd = 1'b1;         // uart transmit, idle high
    logic rxd;
    logic ir_in;
    logic ir_out;
    logic req = 1'b0;
    logic [7:0] plen = 8'h00;
    logic [7:0] width;
    int err_total = 0;
    int checks = 0;
    int k;
    int j;
    always #12.5 i_core_clk = ~i_core_clk;
    // baud made from the core clock keeps each phase two cycles wide
    always @(posedge i_core_clk)
    begin
        bcnt <= bcnt + 2'h1;
        baud <= bcnt[1];
    end
    sir_endec_top dut_u (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_paddr(paddr),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_baud_clk16(baud),
        .i_uart_txd(txd), .o_uart_rxd(rxd), .i_infrared_in(ir_in),
        .o_infrared_out(ir_out));
    // transceiver wired straight to the pins, the alternate-function route;
    // no modem lines reach the block, so none can raise status changes
    sir_xcvr_model xcvr_u (.i_clk(i_core_clk), .i_led(ir_out), .i_req(req),
        .i_len(plen), .o_rxd(ir_in), .o_width(width));
    // ****************************************
    // compare, bus and link tasks
    // ****************************************
    task automatic end_sim;
        if (err_total == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] got);
        checks++;
        if (got !== x)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, x, got);
        end
    endtask
    // cycle counts drift with baud phase, so a window is accepted
    task automatic chk_rng(input string nm, input int lo, input int hi, input int got);
        checks++;
        if (got < lo || got > hi)
        begin
            err_total++;
            $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge i_core_clk);
        pen <= 1'b1;
        @(posedge i_core_clk);
        while (pready !== 1'b1 && n < 16)
        begin
            n++;
            @(posedge i_core_clk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (n == 16)
        begin
            chk("pready", 32'h0000_0001, 32'h0000_0000);
            end_sim();
        end
        // idle cycle so the next setup never lands in this time step
        @(posedge i_core_clk);
    endtask
    task automatic wr(input logic [7:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, sir_pkg::CTRL_ADDR, {24'h00_0000, d}, q, e);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] x, input logic ex);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0000_0000, q, e);
        chk("prdata", x, q);
        chk("pslverr", {31'h0, ex}, {31'h0, e});
    endtask
    task automatic tx_bit(input logic b, input int n, output int hi, output int lo);
        hi = 0;
        lo = 0;
        txd <= b;
        repeat (n)
        begin
            @(posedge i_core_clk);
            if (ir_out === 1'b1)
                hi++;
            if (rxd === 1'b0)
                lo++;
        end
    endtask
    task automatic rx_pulse(input logic [7:0] l, input int n, output int lo);
        req <= 1'b1;
        plen <= l;
        @(posedge i_core_clk);
        req <= 1'b0;
        lo = 0;
        repeat (n)
        begin
            @(posedge i_core_clk);
            if (rxd === 1'b0)
                lo++;
        end
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        repeat (10) @(posedge i_core_clk);
        i_resetn <= 1'b1;
        @(posedge i_core_clk);
        chk("o_infrared_out", 32'h0000_0000, {31'h0, ir_out});
        chk("o_uart_rxd", 32'h0000_0001, {31'h0, rxd});
        rdchk(sir_pkg::CTRL_ADDR, 32'h0000_0000, 1'b0);
        wr(8'hff);
        rdchk(sir_pkg::CTRL_ADDR, 32'h0000_00f7, 1'b0);
        rdchk(12'h000, 32'h0000_0000, 1'b1);
        // transmit only: two zeros then a one
        wr(8'h01);
        tx_bit(1'b0, 128, k, j);
        chk_rng("zero pulses", 24, 24, k);
        chk("pulse width", 32'h0000_000c, {24'h00_0000, width});
        chk_rng("rxd while rx off", 0, 0, j);
        tx_bit(1'b1, 64, k, j);
        chk_rng("one bit", 0, 0, k);
        // receive decode on blocks the pin
        wr(8'h03);
        tx_bit(1'b0, 64, k, j);
        chk_rng("half duplex", 0, 0, k);
        tx_bit(1'b1, 64, k, j);
        // loopback reaches the decoder while the pin stays quiet
        wr(8'h07);
        tx_bit(1'b0, 64, k, j);
        chk_rng("loop pin", 0, 0, k);
        chk_rng("loop rxd", 1, 64, j);
        tx_bit(1'b1, 120, k, j);
        // edge mode accepts any pulse
        wr(8'h03);
        rx_pulse(8'h0c, 100, k);
        chk_rng("edge zero", 60, 68, k);
        rx_pulse(8'h04, 100, k);
        chk_rng("edge short", 60, 68, k);
        rx_pulse(8'h0c, 64, k);
        rx_pulse(8'h0c, 100, j);
        chk_rng("two zeros", 122, 132, k + j);
        // factor 1: more than 8 cycles, at most 4 ticks
        // factors kept small so the legal window fits the fast bench baud
        wr(8'h13);
        rx_pulse(8'h06, 100, k);
        chk_rng("short dropped", 0, 0, k);
        rx_pulse(8'h0c, 100, k);
        chk_rng("legal pulse", 60, 68, k);
        rx_pulse(8'h18, 100, k);
        chk_rng("long dropped", 0, 0, k);
        rx_pulse(8'h0a, 100, k);
        chk_rng("factor one 10", 60, 68, k);
        // factor 2: more than 12 cycles needed
        wr(8'h23);
        rx_pulse(8'h0a, 100, k);
        chk_rng("factor two 10", 0, 0, k);
        rx_pulse(8'h0e, 100, k);
        chk_rng("factor two 14", 60, 68, k);
        // block off or receive off keeps the line idle
        wr(8'h02);
        rx_pulse(8'h0c, 100, k);
        chk_rng("endec off rx", 0, 0, k);
        wr(8'h01);
        rx_pulse(8'h0c, 100, k);
        chk_rng("rx off", 0, 0, k);
        wr(8'h00);
        tx_bit(1'b0, 64, k, j);
        chk_rng("endec off tx", 0, 0, k);
        end_sim();
    end
endmodule
`default_nettype wire
